// ==== mpl_pkg.sv ====
// constants shared by the motor protection and lockout supervisor
`default_nettype none
package mpl_pkg;
  // apb register byte offsets
  localparam logic [7:0] MPL_OFF_MASK = 8'h00;
  localparam logic [7:0] MPL_OFF_CFG = 8'h04;
  localparam logic [7:0] MPL_OFF_CTRL = 8'h08;
  localparam logic [7:0] MPL_OFF_STATUS = 8'h0C;
  localparam logic [7:0] MPL_OFF_COAST_RD = 8'h10;
  localparam logic [7:0] MPL_OFF_STARTS_RD = 8'h14;
  localparam logic [7:0] MPL_OFF_INTERVAL_RD = 8'h18;
  localparam logic [7:0] MPL_OFF_RTC = 8'h1C;

  // protection_enable_mask
  localparam logic [7:0] MPL_MASK_RESET = 8'h7E;
  localparam logic [7:0] MPL_MASK_MIN = 8'h01;
  localparam logic [7:0] MPL_MASK_MAX = 8'h7F;
  localparam int MPL_BIT_ROT_EN = 0;
  localparam int MPL_BIT_SEQ_ABC = 1;
  localparam int MPL_BIT_PCL_EN = 2;
  localparam int MPL_BIT_SCR_EN = 3;
  localparam int MPL_BIT_SHUNT_EN = 4;
  localparam int MPL_BIT_PTC_EN = 5;
  localparam int MPL_BIT_LINE_EN = 6;

  // configuration register, one setting per byte lane
  localparam int MPL_CFG_GFD_LSB = 0;
  localparam int MPL_CFG_COAST_LSB = 8;
  localparam int MPL_CFG_SPH_LSB = 16;
  localparam int MPL_CFG_MSI_LSB = 24;
  localparam logic [5:0] MPL_GFD_RESET = 6'h02;
  localparam logic [5:0] MPL_GFD_MIN = 6'h01;
  localparam logic [5:0] MPL_MINUTES_MAX = 6'h3C;
  localparam logic [5:0] MPL_GFD_MAX = 6'h3C;
  localparam logic [3:0] MPL_SPH_MAX = 4'hA;

  // control register bits
  localparam int MPL_CTRL_CLEAR = 0;
  localparam int MPL_CTRL_TRIP_RESET = 1;

  // trip vector and status layout
  localparam int MPL_TRIP_ROT = 0;
  localparam int MPL_TRIP_GF = 1;
  localparam int MPL_TRIP_PCL = 2;
  localparam int MPL_TRIP_SHUNT = 3;
  localparam int MPL_TRIP_PTC = 4;
  localparam int MPL_TRIPS = 5;
  localparam int MPL_ST_LINE = 5;
  localparam int MPL_ST_COAST = 8;
  localparam int MPL_ST_SPH = 9;
  localparam int MPL_ST_MSI = 10;
  localparam int MPL_ST_SCR = 11;
  localparam int MPL_ST_RUN = 12;
  localparam int MPL_RD_WIN_LSB = 16;

  // timing
  localparam longint MPL_CLK_HZ = 125000000;
  localparam longint MPL_TICK_PERIOD_S = 1;
  localparam int unsigned MPL_TICK_CYCLES = 32'(MPL_CLK_HZ * MPL_TICK_PERIOD_S);
  localparam logic [31:0] MPL_SEC_PER_MIN = 32'h0000003C;
  localparam logic [31:0] MPL_WINDOW_S = 32'h00000E10;
  localparam logic [1:0] MPL_PCL_DELAY_S = 2'h3;
endpackage : mpl_pkg
`default_nettype wire

// ==== mpl_supervisor.sv ====
// motor protection and restart lockout supervisor with apb registers
//
// The implementer's own choices: the placing of the registers and register access over APB.
`default_nettype none
module mpl_supervisor #(
  parameter int unsigned TICK_CYCLES = mpl_pkg::MPL_TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // start control and unit state
  input wire logic start_cmd,
  input wire logic two_wire_mode,
  input wire logic unit_running,
  input wire logic unit_bypass,
  input wire logic unit_accelerating,
  // line sensing
  input wire logic ground_over_level,
  input wire logic rotation_valid,
  input wire logic rotation_is_abc,
  input wire logic [2:0] phase_current_low,
  input wire logic [2:0] phase_current_flow,
  input wire logic scr_drop_absent,
  input wire logic ptc_over,
  input wire logic ptc_open,
  input wire logic [2:0] line_voltage_ok,
  // outputs
  output logic motor_run,
  output logic trip,
  output logic shunt_trip,
  output logic line_phase_loss,
  output logic lockout,
  output logic restart_inhibit
);

  typedef struct packed {
    logic [31:0] prescale;
    logic tick;
    logic [31:0] rtc;
    logic [7:0] mask;
    logic [5:0] gf_delay;
    logic [5:0] coast_min;
    logic [3:0] sph_limit;
    logic [5:0] interval_min;
    logic [5:0] gf_secs;
    logic [1:0] pcl_secs;
    logic start_d;
    logic run;
    logic [mpl_pkg::MPL_TRIPS-1:0] trips;
    logic line_trip;
    logic scr_lock;
    logic coast_armed;
    logic [31:0] stop_stamp;
    logic win_active;
    logic [31:0] win_stamp;
    logic [3:0] start_count;
    logic interval_armed;
    logic [31:0] start_stamp;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trip;
    logic shunt_trip;
    logic lockout;
    logic restart_inhibit;
  } mpl_state_t;

  mpl_state_t st;
  mpl_state_t next_st;

  function automatic logic [31:0] mpl_min_to_s(input logic [5:0] m);
    mpl_min_to_s = 32'(m) * mpl_pkg::MPL_SEC_PER_MIN;
  endfunction : mpl_min_to_s

  // wrap-safe elapsed seconds against the real-time base
  function automatic logic [31:0] mpl_elapsed(input logic [31:0] now, input logic [31:0] stamp);
    mpl_elapsed = now - stamp;
  endfunction : mpl_elapsed

  function automatic logic [31:0] mpl_remain(input logic [31:0] total, input logic [31:0] el);
    mpl_remain = (el < total) ? (total - el) : 32'h00000000;
  endfunction : mpl_remain

  logic unit_off;
  logic apb_setup;
  logic apb_write;
  logic [31:0] coast_left;
  logic [31:0] win_left;
  logic [31:0] interval_left;
  logic coast_lk;
  logic sph_lk;
  logic msi_lk;
  logic lock_any;
  logic tripped;
  logic start_req;
  logic start_ok;
  logic trip_reset;
  logic emerg_clear;
  logic [31:0] status_word;

  always_comb begin
    next_st = st;
    unit_off = ~unit_running & ~unit_bypass & ~st.run;
    apb_setup = psel & ~penable;
    apb_write = psel & penable & pwrite & st.pready;

    // one-second tick and real-time base
    next_st.tick = 1'b0;
    if (st.prescale == 32'(TICK_CYCLES - 1)) begin
      next_st.prescale = 32'h00000000;
      next_st.tick = 1'b1;
    end else begin
      next_st.prescale = st.prescale + 32'h00000001;
    end
    if (st.tick) begin
      next_st.rtc = st.rtc + 32'h00000001;
    end

    // lockout evaluation against the time base
    coast_left = mpl_remain(mpl_min_to_s(st.coast_min), mpl_elapsed(st.rtc, st.stop_stamp));
    win_left = mpl_remain(mpl_pkg::MPL_WINDOW_S, mpl_elapsed(st.rtc, st.win_stamp));
    interval_left = mpl_remain(mpl_min_to_s(st.interval_min),
                               mpl_elapsed(st.rtc, st.start_stamp));
    coast_lk = (st.coast_min != 6'h00) && st.coast_armed && (coast_left != 32'h00000000);
    // a further start would exceed the limit, so it is refused
    sph_lk = (st.sph_limit != 4'h0) && st.win_active && (st.start_count >= st.sph_limit);
    msi_lk = (st.interval_min != 6'h00) && st.interval_armed &&
             (interval_left != 32'h00000000);
    lock_any = coast_lk | sph_lk | msi_lk | st.scr_lock;
    tripped = (|st.trips) | st.line_trip;

    // hour window closes one hour after the start that opened it
    if (st.win_active && (win_left == 32'h00000000)) begin
      next_st.win_active = 1'b0;
      next_st.start_count = 4'h0;
    end

    // software controls
    trip_reset = apb_write && (paddr == mpl_pkg::MPL_OFF_CTRL) && pstrb[0] &&
                 pwdata[mpl_pkg::MPL_CTRL_TRIP_RESET];
    emerg_clear = apb_write && (paddr == mpl_pkg::MPL_OFF_CTRL) && pstrb[0] &&
                  pwdata[mpl_pkg::MPL_CTRL_CLEAR];
    if (trip_reset) begin
      next_st.trips = '0;
    end
    if (emerg_clear) begin
      next_st.coast_armed = 1'b0;
      next_st.win_active = 1'b0;
      next_st.start_count = 4'h0;
      next_st.interval_armed = 1'b0;
      next_st.scr_lock = 1'b0;
    end

    // start handling: maintained level restarts when lockouts lapse
    next_st.start_d = start_cmd;
    start_req = two_wire_mode ? start_cmd : (start_cmd & ~st.start_d);
    start_ok = start_req & ~st.run & ~lock_any & ~tripped;
    if (start_ok) begin
      next_st.run = 1'b1;
      next_st.pcl_secs = 2'h0;
      next_st.start_stamp = st.rtc;
      next_st.interval_armed = 1'b1;
      if (st.win_active && (win_left != 32'h00000000)) begin
        next_st.start_count = st.start_count + 4'h1;
      end else begin
        next_st.win_active = 1'b1;
        next_st.win_stamp = st.rtc;
        next_st.start_count = 4'h1;
      end
    end else if (st.run && (~start_cmd || tripped)) begin
      next_st.run = 1'b0;
      next_st.stop_stamp = st.rtc;
      next_st.coast_armed = 1'b1;
    end

    // ground fault qualification, strictly longer than the delay
    if (!ground_over_level) begin
      next_st.gf_secs = 6'h00;
    end else if (st.tick && (st.gf_secs != 6'h3F)) begin
      next_st.gf_secs = st.gf_secs + 6'h01;
    end
    if (ground_over_level && (st.gf_secs > st.gf_delay)) begin
      next_st.trips[mpl_pkg::MPL_TRIP_GF] = 1'b1;
    end

    // rotation check; sequence bit only matters when enabled
    if (st.mask[mpl_pkg::MPL_BIT_ROT_EN] && rotation_valid &&
        (rotation_is_abc != st.mask[mpl_pkg::MPL_BIT_SEQ_ABC])) begin
      next_st.trips[mpl_pkg::MPL_TRIP_ROT] = 1'b1;
    end

    // running phase current loss three seconds after the start
    if (st.run && st.tick && (st.pcl_secs != mpl_pkg::MPL_PCL_DELAY_S)) begin
      next_st.pcl_secs = st.pcl_secs + 2'h1;
    end
    if (st.mask[mpl_pkg::MPL_BIT_PCL_EN] && st.run &&
        (st.pcl_secs == mpl_pkg::MPL_PCL_DELAY_S) && (|phase_current_low)) begin
      next_st.trips[mpl_pkg::MPL_TRIP_PCL] = 1'b1;
    end

    // shorted scr only visible with the unit off; blocks the next start
    if (st.mask[mpl_pkg::MPL_BIT_SCR_EN] && unit_off && scr_drop_absent) begin
      next_st.scr_lock = 1'b1;
    end

    // current while off means welded or shorted path upstream
    if (st.mask[mpl_pkg::MPL_BIT_SHUNT_EN] && unit_off && (|phase_current_flow)) begin
      next_st.trips[mpl_pkg::MPL_TRIP_SHUNT] = 1'b1;
    end

    // thermistor
    if (st.mask[mpl_pkg::MPL_BIT_PTC_EN] && (ptc_over || ptc_open)) begin
      next_st.trips[mpl_pkg::MPL_TRIP_PTC] = 1'b1;
    end

    // line phase loss follows the line, no latch
    next_st.line_trip = st.mask[mpl_pkg::MPL_BIT_LINE_EN] && ~unit_accelerating &&
                        ~(&line_voltage_ok);

    // register writes
    if (apb_write && (paddr == mpl_pkg::MPL_OFF_MASK) && pstrb[0] &&
        (pwdata[7:0] >= mpl_pkg::MPL_MASK_MIN) && (pwdata[7:0] <= mpl_pkg::MPL_MASK_MAX)) begin
      next_st.mask = pwdata[7:0];
    end
    if (apb_write && (paddr == mpl_pkg::MPL_OFF_CFG)) begin
      if (pstrb[0] && (pwdata[mpl_pkg::MPL_CFG_GFD_LSB +: 6] >= mpl_pkg::MPL_GFD_MIN) &&
          (pwdata[mpl_pkg::MPL_CFG_GFD_LSB +: 6] <= mpl_pkg::MPL_GFD_MAX)) begin
        next_st.gf_delay = pwdata[mpl_pkg::MPL_CFG_GFD_LSB +: 6];
      end
      if (pstrb[1] && (pwdata[mpl_pkg::MPL_CFG_COAST_LSB +: 6] <= mpl_pkg::MPL_MINUTES_MAX)) begin
        next_st.coast_min = pwdata[mpl_pkg::MPL_CFG_COAST_LSB +: 6];
      end
      if (pstrb[2] && (pwdata[mpl_pkg::MPL_CFG_SPH_LSB +: 4] <= mpl_pkg::MPL_SPH_MAX)) begin
        next_st.sph_limit = pwdata[mpl_pkg::MPL_CFG_SPH_LSB +: 4];
      end
      if (pstrb[3] && (pwdata[mpl_pkg::MPL_CFG_MSI_LSB +: 6] <= mpl_pkg::MPL_MINUTES_MAX)) begin
        next_st.interval_min = pwdata[mpl_pkg::MPL_CFG_MSI_LSB +: 6];
      end
    end
    // battery-backed time restored by software after power-up
    if (apb_write && (paddr == mpl_pkg::MPL_OFF_RTC) && (&pstrb)) begin
      next_st.rtc = pwdata;
    end

    // read path, captured in the setup cycle; zero-wait access phase
    status_word = 32'h00000000;
    status_word[mpl_pkg::MPL_TRIPS-1:0] = st.trips;
    status_word[mpl_pkg::MPL_ST_LINE] = st.line_trip;
    status_word[mpl_pkg::MPL_ST_COAST] = coast_lk;
    status_word[mpl_pkg::MPL_ST_SPH] = sph_lk;
    status_word[mpl_pkg::MPL_ST_MSI] = msi_lk;
    status_word[mpl_pkg::MPL_ST_SCR] = st.scr_lock;
    status_word[mpl_pkg::MPL_ST_RUN] = st.run;
    next_st.pready = apb_setup;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h00000000;
    if (apb_setup && !pwrite) begin
      case (paddr)
        mpl_pkg::MPL_OFF_MASK: next_st.prdata = {24'h000000, st.mask};
        mpl_pkg::MPL_OFF_CFG: next_st.prdata = {2'h0, st.interval_min, 4'h0, st.sph_limit,
                                                2'h0, st.coast_min, 2'h0, st.gf_delay};
        mpl_pkg::MPL_OFF_CTRL: next_st.prdata = 32'h00000000;
        mpl_pkg::MPL_OFF_STATUS: next_st.prdata = status_word;
        mpl_pkg::MPL_OFF_COAST_RD: next_st.prdata = coast_lk ? coast_left : 32'h00000000;
        mpl_pkg::MPL_OFF_STARTS_RD: next_st.prdata = {4'h0,
            (st.win_active ? win_left[11:0] : 12'h000), 12'h000, st.start_count};
        mpl_pkg::MPL_OFF_INTERVAL_RD: next_st.prdata = msi_lk ? interval_left : 32'h00000000;
        mpl_pkg::MPL_OFF_RTC: next_st.prdata = st.rtc;
        default: next_st.pslverr = 1'b1;
      endcase
    end else if (apb_setup) begin
      case (paddr)
        mpl_pkg::MPL_OFF_MASK, mpl_pkg::MPL_OFF_CFG, mpl_pkg::MPL_OFF_CTRL,
        mpl_pkg::MPL_OFF_STATUS, mpl_pkg::MPL_OFF_COAST_RD, mpl_pkg::MPL_OFF_STARTS_RD,
        mpl_pkg::MPL_OFF_INTERVAL_RD, mpl_pkg::MPL_OFF_RTC: next_st.pslverr = 1'b0;
        default: next_st.pslverr = 1'b1;
      endcase
    end

    // registered summary outputs
    next_st.trip = (|next_st.trips) | next_st.line_trip;
    next_st.shunt_trip = next_st.trips[mpl_pkg::MPL_TRIP_SHUNT];
    next_st.lockout = lock_any;
    next_st.restart_inhibit = lock_any | tripped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.mask <= mpl_pkg::MPL_MASK_RESET;
      st.gf_delay <= mpl_pkg::MPL_GFD_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign motor_run = st.run;
  assign trip = st.trip;
  assign shunt_trip = st.shunt_trip;
  assign line_phase_loss = st.line_trip;
  assign lockout = st.lockout;
  assign restart_inhibit = st.restart_inhibit;
endmodule : mpl_supervisor
`default_nettype wire

// ==== mpl_supervisor_asserts.sv ====
// port-level assertions for the protection and lockout supervisor
`default_nettype none
module mpl_supervisor_chk #(
  parameter int unsigned TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // start, sensing and outputs
  input wire logic start_cmd,
  input wire logic [2:0] line_voltage_ok,
  input wire logic motor_run,
  input wire logic trip,
  input wire logic shunt_trip,
  input wire logic line_phase_loss
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pwrite && paddr == mpl_pkg::MPL_OFF_CTRL;
  property p_pready; psel && !penable |=> pready; endproperty
  a_pready: assert property (p_pready) else $error("no answer after setup");
  property p_pready_one; pready |=> !pready; endproperty
  a_pready_one: assert property (p_pready_one) else $error("answer held too long");
  property p_slverr; pslverr |-> pready; endproperty
  a_slverr: assert property (p_slverr) else $error("error without answer");
  property p_rdata; !pready |-> prdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside answer");
  property p_run_rise; $rose(motor_run) |-> $past(start_cmd); endproperty
  a_run_rise: assert property (p_run_rise) else $error("run without command");
  property p_stop; !start_cmd |=> !motor_run; endproperty
  a_stop: assert property (p_stop) else $error("run after command dropped");
  property p_trip_stop; trip && !line_phase_loss |=> !motor_run; endproperty
  a_trip_stop: assert property (p_trip_stop) else $error("run during trip");
  property p_shunt_hold; shunt_trip && !ctrl_wr |=> shunt_trip; endproperty
  a_shunt_hold: assert property (p_shunt_hold) else $error("shunt trip lost");
  property p_line_trip; line_phase_loss |-> trip; endproperty
  a_line_trip: assert property (p_line_trip) else $error("line loss not a trip");
  property p_line_clr; line_phase_loss && (&line_voltage_ok) |=> !line_phase_loss; endproperty
  a_line_clr: assert property (p_line_clr) else $error("line loss stuck");
  c_run: cover property ($rose(motor_run));
  c_trip: cover property ($rose(trip));
  c_err: cover property (pslverr);
endmodule : mpl_supervisor_chk
`default_nettype wire

// ==== mpl_line_model.sv ====
// behavioural motor and line model feeding the supervisor sensing inputs
`default_nettype none
module mpl_line_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // starter command and fault injection
  input wire logic motor_run,
  input wire logic leak,
  input wire logic line_cut,
  input wire logic cur_low,
  // unit state and sensing
  output logic unit_running,
  output logic unit_bypass,
  output logic unit_accelerating,
  output logic [2:0] phase_current_low,
  output logic [2:0] phase_current_flow,
  output logic [2:0] line_voltage_ok
);
  logic [2:0] ramp;
  // motor lags the command by a cycle, so current never leads the run state unless leak is injected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp <= 3'h0;
      unit_running <= 1'b0;
      unit_bypass <= 1'b0;
      unit_accelerating <= 1'b0;
      phase_current_low <= 3'h7;
      phase_current_flow <= 3'h0;
      line_voltage_ok <= 3'h7;
    end else begin
      ramp <= !motor_run ? 3'h0 : (ramp == 3'h4 ? ramp : ramp + 3'h1);
      unit_running <= motor_run;
      unit_accelerating <= motor_run && ramp != 3'h4;
      unit_bypass <= motor_run && ramp == 3'h4;
      phase_current_flow <= (motor_run || leak) ? 3'h7 : 3'h0;
      // a stopped motor draws nothing, so every phase reads low
      phase_current_low <= motor_run ? {cur_low, 2'h0} : 3'h7;
      line_voltage_ok <= line_cut ? 3'h5 : 3'h7;
    end
  end
endmodule : mpl_line_model
`default_nettype wire

// ==== mpl_supervisor_tb_top.sv ====
// self-checking bench for the protection and lockout supervisor
`default_nettype none
module mpl_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TICK = 10;
  localparam logic [7:0] A_MASK = mpl_pkg::MPL_OFF_MASK;
  localparam logic [7:0] A_CFG = mpl_pkg::MPL_OFF_CFG;
  localparam logic [7:0] A_CTRL = mpl_pkg::MPL_OFF_CTRL;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hF;
  logic start_cmd = 0, two_wire_mode = 0, ground_over_level = 0, rotation_valid = 0;
  logic rotation_is_abc = 0, scr_drop_absent = 0, ptc_over = 0, ptc_open = 0;
  logic leak = 0, line_cut = 0, cur_low = 0, pready, pslverr, motor_run, trip;
  logic unit_running, unit_bypass, unit_accelerating, shunt_trip, line_phase_loss;
  logic lockout, restart_inhibit;
  logic [2:0] phase_current_low, phase_current_flow, line_voltage_ok;
  int errors = 0, compares = 0, cycles = 0;
  always #4 pclk = ~pclk;
  mpl_supervisor #(.TICK_CYCLES(TICK)) mpl_supervisor_inst (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_cmd(start_cmd), .two_wire_mode(two_wire_mode), .unit_running(unit_running),
    .unit_bypass(unit_bypass), .unit_accelerating(unit_accelerating),
    .ground_over_level(ground_over_level), .rotation_valid(rotation_valid),
    .rotation_is_abc(rotation_is_abc), .phase_current_low(phase_current_low),
    .phase_current_flow(phase_current_flow), .scr_drop_absent(scr_drop_absent),
    .ptc_over(ptc_over), .ptc_open(ptc_open), .line_voltage_ok(line_voltage_ok),
    .motor_run(motor_run), .trip(trip), .shunt_trip(shunt_trip),
    .line_phase_loss(line_phase_loss), .lockout(lockout), .restart_inhibit(restart_inhibit));
  mpl_line_model mpl_line_model_inst (.pclk(pclk), .presetn(presetn), .motor_run(motor_run),
    .leak(leak), .line_cut(line_cut), .cur_low(cur_low), .unit_running(unit_running),
    .unit_bypass(unit_bypass), .unit_accelerating(unit_accelerating),
    .phase_current_low(phase_current_low), .phase_current_flow(phase_current_flow),
    .line_voltage_ok(line_voltage_ok));
  task automatic give_verdict;
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 50000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: register %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // no wait count assumed; only the cycle ceiling ends a hung access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic t_regs;
    apb(0, A_MASK, 32'h0);
    chk32(r, 32'h7E);
    apb(0, A_CFG, 32'h0);
    chk32(r, 32'h2);
    apb(1, A_MASK, 32'h80);
    apb(1, A_MASK, 32'h0);
    apb(0, A_MASK, 32'h0);
    chk32(r, 32'h7E);
    apb(0, 8'h40, 32'h0);
    chk1(e, 1'b1);
    // at most one tick lands between write and read, so the low nibble is left out
    apb(1, mpl_pkg::MPL_OFF_RTC, 32'h12345670);
    apb(0, mpl_pkg::MPL_OFF_RTC, 32'h0);
    chk32({4'h0, r[31:4]}, 32'h01234567);
  endtask : t_regs
  task automatic t_rot;
    rotation_valid <= 1'b1;
    cyc(3);
    chk1(trip, 1'b0);
    apb(1, A_MASK, 32'h7F);
    cyc(3);
    chk1(trip, 1'b1);
    apb(1, A_MASK, 32'h7D);
    apb(1, A_CTRL, 32'h2);
    cyc(3);
    chk1(trip, 1'b0);
    rotation_valid <= 1'b0;
    apb(1, A_MASK, 32'h7E);
  endtask : t_rot
  // sample points sit clear of the tick phase: at most 2, then at least 4 ticks
  task automatic t_gf;
    ground_over_level <= 1'b1;
    cyc(15);
    chk1(trip, 1'b0);
    cyc(30);
    chk1(trip, 1'b1);
    ground_over_level <= 1'b0;
    cyc(30);
    chk1(trip, 1'b1);
    chk1(restart_inhibit, 1'b1);
    apb(1, A_CTRL, 32'h2);
    cyc(2);
    chk1(trip, 1'b0);
    chk1(restart_inhibit, 1'b0);
  endtask : t_gf
  task automatic t_shunt_ptc;
    leak <= 1'b1;
    cyc(4);
    chk1(shunt_trip, 1'b1);
    leak <= 1'b0;
    ptc_open <= 1'b1;
    cyc(10);
    chk1(shunt_trip, 1'b1);
    chk1(trip, 1'b1);
    ptc_open <= 1'b0;
    apb(1, A_MASK, 32'h5E);
    ptc_over <= 1'b1;
    apb(1, A_CTRL, 32'h2);
    cyc(3);
    chk1(trip, 1'b0);
    ptc_over <= 1'b0;
    apb(1, A_MASK, 32'h7E);
  endtask : t_shunt_ptc
  task automatic t_line;
    two_wire_mode <= 1'b1;
    line_cut <= 1'b1;
    cyc(4);
    chk1(line_phase_loss, 1'b1);
    start_cmd <= 1'b1;
    cyc(4);
    chk1(motor_run, 1'b0);
    line_cut <= 1'b0;
    cyc(6);
    chk1(line_phase_loss, 1'b0);
    chk1(motor_run, 1'b1);
    start_cmd <= 1'b0;
    two_wire_mode <= 1'b0;
    apb(1, A_MASK, 32'h3E);
    line_cut <= 1'b1;
    cyc(4);
    chk1(line_phase_loss, 1'b0);
    line_cut <= 1'b0;
    apb(1, A_MASK, 32'h7E);
  endtask : t_line
  task automatic t_scr;
    start_cmd <= 1'b1;
    cyc(3);
    scr_drop_absent <= 1'b1;
    cyc(3);
    scr_drop_absent <= 1'b0;
    start_cmd <= 1'b0;
    cyc(3);
    chk1(lockout, 1'b0);
    scr_drop_absent <= 1'b1;
    cyc(3);
    scr_drop_absent <= 1'b0;
    start_cmd <= 1'b1;
    cyc(3);
    chk1(lockout, 1'b1);
    chk1(motor_run, 1'b0);
    start_cmd <= 1'b0;
    apb(1, A_CTRL, 32'h1);
    cyc(2);
    chk1(lockout, 1'b0);
  endtask : t_scr
  task automatic t_pcl;
    cur_low <= 1'b1;
    start_cmd <= 1'b1;
    cyc(15);
    chk1(trip, 1'b0);
    cyc(30);
    chk1(trip, 1'b1);
    start_cmd <= 1'b0;
    cur_low <= 1'b0;
    apb(1, A_CTRL, 32'h2);
  endtask : t_pcl
  task automatic t_msi;
    apb(1, A_CFG, 32'h01000002);
    start_cmd <= 1'b1;
    cyc(3);
    start_cmd <= 1'b0;
    cyc(3);
    start_cmd <= 1'b1;
    cyc(3);
    chk1(motor_run, 1'b0);
    apb(0, mpl_pkg::MPL_OFF_STATUS, 32'h0);
    chk1(r[mpl_pkg::MPL_ST_MSI], 1'b1);
    apb(1, A_CTRL, 32'h1);
    start_cmd <= 1'b0;
    cyc(2);
    start_cmd <= 1'b1;
    cyc(3);
    chk1(motor_run, 1'b1);
    start_cmd <= 1'b0;
    apb(1, A_CFG, 32'h2);
    apb(1, A_CTRL, 32'h1);
  endtask : t_msi
  // one minute is 60 ticks; restart must wait for it, then come unasked
  task automatic t_coast;
    apb(1, A_CFG, 32'h00000102);
    two_wire_mode <= 1'b1;
    start_cmd <= 1'b1;
    cyc(4);
    start_cmd <= 1'b0;
    cyc(2);
    start_cmd <= 1'b1;
    cyc(500);
    chk1(motor_run, 1'b0);
    apb(0, mpl_pkg::MPL_OFF_COAST_RD, 32'h0);
    chk1((r > 32'h0) && (r <= 32'h3C), 1'b1);
    for (int i = 0; i < 300 && motor_run !== 1'b1; i++) @(posedge pclk);
    chk1(motor_run, 1'b1);
    start_cmd <= 1'b0;
    two_wire_mode <= 1'b0;
    apb(1, A_CFG, 32'h2);
    apb(1, A_CTRL, 32'h1);
  endtask : t_coast
  task automatic t_sph;
    apb(1, A_CFG, 32'h00010002);
    start_cmd <= 1'b1;
    cyc(3);
    start_cmd <= 1'b0;
    cyc(3);
    start_cmd <= 1'b1;
    cyc(3);
    chk1(motor_run, 1'b0);
    apb(0, mpl_pkg::MPL_OFF_STARTS_RD, 32'h0);
    chk32({28'h0, r[3:0]}, 32'h1);
    start_cmd <= 1'b0;
    cyc(36030);
    start_cmd <= 1'b1;
    cyc(3);
    chk1(motor_run, 1'b1);
    start_cmd <= 1'b0;
  endtask : t_sph
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_rot();
    t_gf();
    t_shunt_ptc();
    t_line();
    t_scr();
    t_pcl();
    t_msi();
    t_coast();
    t_sph();
    give_verdict();
  end
endmodule : mpl_supervisor_tb_top
bind mpl_supervisor mpl_supervisor_chk #(.TICK_CYCLES(TICK_CYCLES)) mpl_supervisor_chk_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .start_cmd(start_cmd), .line_voltage_ok(line_voltage_ok), .motor_run(motor_run),
  .trip(trip), .shunt_trip(shunt_trip), .line_phase_loss(line_phase_loss));
`default_nettype wire
